/* File: pkg/lcdi_defines.svh */
// Constants of the display driver serial write slave
`ifndef LCDI_DEFINES_SVH
`define LCDI_DEFINES_SVH

// ==========================================================
// Slave address byte
`define LCDI_ADDR_PREFIX 6'h1c
`define LCDI_ADDR_RW_BIT 0

// ==========================================================
// Control byte fields
`define LCDI_CTRL_CONT_BIT 7
`define LCDI_CTRL_SEL_BIT 6

// ==========================================================
// Bit counter values within one byte frame
`define LCDI_CNT_W 4
`define LCDI_CNT_FIRST 4'h0
`define LCDI_CNT_LAST_DATA 4'h7
`define LCDI_CNT_ACK 4'h8

// ==========================================================
// Synchroniser and byte widths
`define LCDI_PIN_SYNC_W 2
`define LCDI_CFG_SYNC_W 8
`define LCDI_BYTE_W 8

`endif

/* File: pkg/lcdi_pkg.sv */
// Types of the display driver serial write slave
package lcdi_pkg;

  // ==========================================================
  // Byte parser states
  typedef enum logic [4:0] {
    st_idle = 5'h01,
    st_addr = 5'h02,
    st_ctrl = 5'h04,
    st_data = 5'h08,
    st_skip = 5'h10
  } lcdi_state_e;

  // ==========================================================
  // Byte handed from the link domain to the system domain
  typedef struct packed {
    logic is_display;
    logic is_mine;
    logic [7:0] data;
  } lcdi_evt_s;

  // ==========================================================
  // Straps and system state seen by the link domain
  typedef struct packed {
    logic ram_end;
    logic [2:0] subaddr_cur;
    logic [2:0] subaddr_strap;
    logic addr_lsb_strap;
  } lcdi_cfg_s;

endpackage

/* File: rtl/lcdi_slave.sv */
// Write-only two-wire serial slave front end of a segment display driver

`include "lcdi_defines.svh"

// Notes on behaviour
// RL1: Slave receiver only; drives acknowledge bits alone.
// RL2: Answers only addresses 0111000 and 0111001.
// RL3: Address bit zero must equal strap level.
// RL4: Read requests get no response at all.
// RL5: Matching devices acknowledge; others ignore until start/stop.
// RL6: Control bit 6 routes to command or display.
// RL7: Control bit 7 set: one byte, then control.
// RL8: Control and command bytes always acknowledged.
// RL9: Display bytes go to RAM at pointer.
// RL10: Display acknowledge only when subaddress matches strap.
// RL11: Subaddress straps decode as binary, low is zero.
// RL12: Master ends with stop or repeated start.
// RL13: Past RAM end, display bytes dropped, unacknowledged.
// RL14: Start or stop resets parser, drops partial byte.
module lcdi_slave (
  // System clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Link sampling clock
  input wire logic link_clk_i,
  // Serial bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  // Straps
  input wire logic addr_lsb_strap_i,
  input wire logic subaddr_strap_bit0_i,
  input wire logic subaddr_strap_bit1_i,
  input wire logic subaddr_strap_bit2_i,
  // State of the display RAM addressing logic
  input wire logic [2:0] subaddr_cur_i,
  input wire logic ram_end_i,
  // Command bytes
  output logic cmd_valid_o,
  output logic [7:0] cmd_data_o,
  // Display bytes
  output logic disp_valid_o,
  output logic disp_mine_o,
  output logic [7:0] disp_data_o
);

  // ==========================================================
  // Link domain reset and input synchronisers
  logic link_rst;
  logic [`LCDI_PIN_SYNC_W-1:0] pins_s;
  lcdi_pkg::lcdi_cfg_s cfg_raw;
  lcdi_pkg::lcdi_cfg_s cfg_s;
  logic scl_s;
  logic sda_s;

  lcdi_sync #(
    .WIDTH(1)
  ) u_rst_sync (
    .clk_i(link_clk_i),
    .async_i(rst_i),
    .sync_o(link_rst)
  );

  lcdi_sync #(
    .WIDTH(`LCDI_PIN_SYNC_W)
  ) u_pin_sync (
    .clk_i(link_clk_i),
    .async_i({scl_i, sda_i}),
    .sync_o(pins_s)
  );

  // Subaddress straps form a binary number, bit0 lowest
  assign cfg_raw.ram_end = ram_end_i;
  assign cfg_raw.subaddr_cur = subaddr_cur_i;
  assign cfg_raw.subaddr_strap = {subaddr_strap_bit2_i, subaddr_strap_bit1_i,
    subaddr_strap_bit0_i}; // RL11
  assign cfg_raw.addr_lsb_strap = addr_lsb_strap_i;

  lcdi_sync #(
    .WIDTH(`LCDI_CFG_SYNC_W)
  ) u_cfg_sync (
    .clk_i(link_clk_i),
    .async_i(cfg_raw),
    .sync_o(cfg_s)
  );

  // Take the word only when two samples agree, so a counter step
  // caught between synchroniser bits never reaches the parser
  lcdi_pkg::lcdi_cfg_s cfg_p_q;
  lcdi_pkg::lcdi_cfg_s cfg_q;
  lcdi_pkg::lcdi_cfg_s cfg_d;

  assign cfg_d = (cfg_s == cfg_p_q) ? cfg_s : cfg_q;

  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  // ==========================================================
  // Link domain registers
  lcdi_pkg::lcdi_state_e state_q;
  lcdi_pkg::lcdi_state_e state_d;
  logic [`LCDI_CNT_W-1:0] cnt_q;
  logic [`LCDI_CNT_W-1:0] cnt_d;
  logic [7:0] shift_q;
  logic [7:0] shift_d;
  logic ack_want_q;
  logic ack_want_d;
  logic oe_n_q;
  logic oe_n_d;
  logic control_continue_flag_q;
  logic control_continue_flag_d;
  logic target_select_flag_q;
  logic target_select_flag_d;
  lcdi_pkg::lcdi_evt_s evt_q;
  lcdi_pkg::lcdi_evt_s evt_d;
  logic evt_tgl_q;
  logic evt_tgl_d;
  logic scl_p_q;
  logic sda_p_q;
  logic sda_out_q;

  // ==========================================================
  // Bus condition decode
  logic bus_start;
  logic bus_stop;
  logic scl_rise;
  logic scl_fall;
  logic byte_done;
  logic [7:0] rx_byte;
  logic [`LCDI_CNT_W-1:0] cnt_inc;

  // Data edges while the clock stays high are frame markers
  assign bus_start = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign bus_stop = scl_s & scl_p_q & ~sda_p_q & sda_s;
  assign scl_rise = scl_s & ~scl_p_q;
  assign scl_fall = ~scl_s & scl_p_q;
  assign byte_done = scl_rise & (cnt_q == `LCDI_CNT_LAST_DATA);
  assign rx_byte = {shift_q[6:0], sda_s};
  assign cnt_inc = cnt_q + `LCDI_CNT_W'(1);

  // ==========================================================
  // Byte classification
  logic addr_hit;
  logic write_req;
  logic sub_hit;
  logic disp_ok;
  logic ctrl_cont;
  logic ctrl_sel;

  assign addr_hit = rx_byte[7:1] == {`LCDI_ADDR_PREFIX, cfg_q.addr_lsb_strap}; // RL2 RL3
  assign write_req = ~rx_byte[`LCDI_ADDR_RW_BIT]; // RL4
  assign sub_hit = cfg_q.subaddr_strap == cfg_q.subaddr_cur; // RL10
  assign disp_ok = sub_hit & ~cfg_q.ram_end; // RL13
  assign ctrl_cont = rx_byte[`LCDI_CTRL_CONT_BIT]; // RL7
  assign ctrl_sel = rx_byte[`LCDI_CTRL_SEL_BIT]; // RL6

  // ==========================================================
  // Parser next state
  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    shift_d = shift_q;
    ack_want_d = ack_want_q;
    oe_n_d = oe_n_q;
    control_continue_flag_d = control_continue_flag_q;
    target_select_flag_d = target_select_flag_q;
    evt_d = evt_q;
    evt_tgl_d = evt_tgl_q;
    if (bus_start)
    begin
      // Fresh frame: expect an address, drop any partial byte
      state_d = lcdi_pkg::st_addr; // RL14
      cnt_d = `LCDI_CNT_FIRST;
      shift_d = 8'h00;
      ack_want_d = 1'b0;
      oe_n_d = 1'b1;
    end
    else if (bus_stop)
    begin
      state_d = lcdi_pkg::st_idle; // RL14
      cnt_d = `LCDI_CNT_FIRST;
      shift_d = 8'h00;
      ack_want_d = 1'b0;
      oe_n_d = 1'b1;
    end
    else
    begin
      if (scl_rise)
      begin
        if (cnt_q == `LCDI_CNT_ACK)
        begin
          cnt_d = `LCDI_CNT_FIRST;
        end
        else
        begin
          shift_d = rx_byte;
          cnt_d = cnt_inc;
        end
      end
      if (byte_done)
      begin
        unique case (state_q)
          lcdi_pkg::st_idle:
          begin
            ack_want_d = 1'b0;
          end
          lcdi_pkg::st_addr:
          begin
            // All matching devices answer together
            ack_want_d = addr_hit & write_req; // RL5
            state_d = (addr_hit & write_req) ? lcdi_pkg::st_ctrl : lcdi_pkg::st_skip; // RL5
          end
          lcdi_pkg::st_ctrl:
          begin
            ack_want_d = 1'b1; // RL8
            control_continue_flag_d = ctrl_cont; // RL7
            target_select_flag_d = ctrl_sel; // RL6
            state_d = lcdi_pkg::st_data;
          end
          lcdi_pkg::st_data:
          begin
            ack_want_d = target_select_flag_q ? disp_ok : 1'b1; // RL8 RL10 RL13
            evt_d.is_display = target_select_flag_q;
            evt_d.is_mine = target_select_flag_q ? disp_ok : 1'b1; // RL9 RL13
            evt_d.data = rx_byte;
            evt_tgl_d = ~evt_tgl_q;
            state_d = control_continue_flag_q ? lcdi_pkg::st_ctrl : lcdi_pkg::st_data; // RL7
          end
          lcdi_pkg::st_skip:
          begin
            ack_want_d = 1'b0; // RL5
          end
        endcase
      end
      if (scl_fall)
      begin
        // Pull the line only through the acknowledge clock
        if ((cnt_q == `LCDI_CNT_ACK) && ack_want_q)
        begin
          oe_n_d = 1'b0; // RL1
          ack_want_d = 1'b0;
        end
        else if (cnt_q == `LCDI_CNT_FIRST)
        begin
          oe_n_d = 1'b1; // RL1
        end
      end
    end
  end

  // ==========================================================
  // Link domain flip-flops
  always_ff @(posedge link_clk_i)
  begin
    if (link_rst)
    begin
      state_q <= lcdi_pkg::st_idle;
      cnt_q <= `LCDI_CNT_FIRST;
      shift_q <= 8'h00;
      ack_want_q <= 1'b0;
      oe_n_q <= 1'b1;
      control_continue_flag_q <= 1'b0;
      target_select_flag_q <= 1'b0;
      evt_q <= '0;
      evt_tgl_q <= 1'b0;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      sda_out_q <= 1'b0;
      cfg_p_q <= '0;
      cfg_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      shift_q <= shift_d;
      ack_want_q <= ack_want_d;
      oe_n_q <= oe_n_d;
      control_continue_flag_q <= control_continue_flag_d;
      target_select_flag_q <= target_select_flag_d;
      evt_q <= evt_d;
      evt_tgl_q <= evt_tgl_d;
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
      sda_out_q <= 1'b0;
      cfg_p_q <= cfg_s;
      cfg_q <= cfg_d;
    end
  end

  // Open-drain data pin: only ever pulled low
  assign sda_o = sda_out_q; // RL1
  assign sda_oe_n_o = oe_n_q;

  // ==========================================================
  // Event crossing into the system domain
  // The event word is held for a whole byte frame, far longer
  // than the toggle takes to cross, so it is sampled directly.
  logic tgl_s;
  logic tgl_p_q;
  logic evt_fire;

  lcdi_sync #(
    .WIDTH(1)
  ) u_tgl_sync (
    .clk_i(clk_i),
    .async_i(evt_tgl_q),
    .sync_o(tgl_s)
  );

  assign evt_fire = tgl_s ^ tgl_p_q;

  // ==========================================================
  // System domain outputs
  logic cmd_valid_q;
  logic [7:0] cmd_data_q;
  logic disp_valid_q;
  logic disp_mine_q;
  logic [7:0] disp_data_q;
  logic fire_cmd;
  logic fire_disp;

  assign fire_cmd = evt_fire & ~evt_q.is_display;
  assign fire_disp = evt_fire & evt_q.is_display;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tgl_p_q <= tgl_s;
      cmd_valid_q <= 1'b0;
      cmd_data_q <= 8'h00;
      disp_valid_q <= 1'b0;
      disp_mine_q <= 1'b0;
      disp_data_q <= 8'h00;
    end
    else
    begin
      tgl_p_q <= tgl_s;
      cmd_valid_q <= fire_cmd;
      disp_valid_q <= fire_disp; // RL9
      if (fire_cmd)
      begin
        cmd_data_q <= evt_q.data;
      end
      if (fire_disp)
      begin
        disp_mine_q <= evt_q.is_mine; // RL9 RL13
        disp_data_q <= evt_q.data;
      end
    end
  end

  assign cmd_valid_o = cmd_valid_q;
  assign cmd_data_o = cmd_data_q;
  assign disp_valid_o = disp_valid_q;
  assign disp_mine_o = disp_mine_q;
  assign disp_data_o = disp_data_q;

endmodule

/* File: rtl/lcdi_sync.sv */
// Two flip-flop level synchroniser
module lcdi_sync #(
  parameter int WIDTH = 1
) (
  // Destination clock
  input wire logic clk_i,
  // Asynchronous level in, synchronised level out
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // ==========================================================
  // First stage feeds only the second stage
  always_ff @(posedge clk_i)
  begin
    meta_q <= async_i;
    sync_q <= meta_q;
  end

  assign sync_o = sync_q;

endmodule

/* File: verification/lcdi_bus_master.sv */
// Bus master model driving the serial clock and open-drain data line
module lcdi_bus_master (
  // Resolved data line
  input wire logic sda_i,
  // Driven lines, high means released
  output logic scl_o,
  output logic sda_o
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int H = 1000;
  initial
  begin
    scl_o = 1'h1;
    sda_o = 1'h1;
  end
  // Start or repeated start from any bus state
  task automatic start();
    sda_o = 1'h1;
    #(H / 2);
    scl_o = 1'h1;
    #H;
    sda_o = 1'h0;
    #H;
    scl_o = 1'h0;
  endtask
  task automatic stop();
    // Lower the clock first so the data edge is not taken as a start
    if (scl_o)
    begin
      scl_o = 1'h0;
      #H;
    end
    sda_o = 1'h0;
    #H;
    scl_o = 1'h1;
    #H;
    sda_o = 1'h1;
    #H;
  endtask
  // Sends n bits MSB first, then the ack clock when the byte is whole
  task automatic send(input logic [7:0] b, input int n, output logic ack);
    ack = 1'h0;
    for (int i = 7; i > 7 - n; i--)
    begin
      #(H / 2);
      sda_o = b[i];
      #(H / 2);
      scl_o = 1'h1;
      #H;
      scl_o = 1'h0;
    end
    if (n == 8)
    begin
      #(H / 2);
      sda_o = 1'h1;
      #(H / 2);
      scl_o = 1'h1;
      #(H / 2);
      ack = !sda_i;
      #(H / 2);
      scl_o = 1'h0;
    end
  endtask
endmodule

/* File: verification/lcdi_slave_asserts.sv */
// Port checker of the serial write slave, bound to its top module
module lcdi_slave_asserts (
  // Clocks and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic link_clk_i,
  // Bus and straps
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic sda_oe_n_o,
  input wire logic subaddr_strap_bit0_i,
  input wire logic subaddr_strap_bit1_i,
  input wire logic subaddr_strap_bit2_i,
  input wire logic [2:0] subaddr_cur_i,
  input wire logic ram_end_i,
  // Byte outputs
  input wire logic cmd_valid_o,
  input wire logic [7:0] cmd_data_o,
  input wire logic disp_valid_o,
  input wire logic disp_mine_o,
  input wire logic [7:0] disp_data_o
);
  wire logic [2:0] strap = {subaddr_strap_bit2_i, subaddr_strap_bit1_i, subaddr_strap_bit0_i};
  wire logic match = (strap == subaddr_cur_i) && !ram_end_i;

  // ==========================================================
  // Link side
  property p_sda_low;
    @(posedge link_clk_i) disable iff (rst_i) sda_o == 1'h0;
  endproperty
  a_sda_low: assert property (p_sda_low) else $error("sda_o not low");
  property p_ack_scl_low;
    @(posedge link_clk_i) disable iff (rst_i) $fell(sda_oe_n_o) |-> !scl_i;
  endproperty
  a_ack_scl_low: assert property (p_ack_scl_low) else $error("ack while scl high");
  property p_ack_len;
    @(posedge link_clk_i) disable iff (rst_i)
      $fell(sda_oe_n_o) |-> !sda_oe_n_o [*8] ##[1:40] sda_oe_n_o;
  endproperty
  a_ack_len: assert property (p_ack_len) else $error("ack length wrong");
  property p_ack_stable;
    @(posedge link_clk_i) disable iff (rst_i) scl_i && $past(scl_i) |-> $stable(sda_oe_n_o);
  endproperty
  a_ack_stable: assert property (p_ack_stable) else $error("ack moved in scl high");

  // ==========================================================
  // System side
  property p_cmd_pulse;
    @(posedge clk_i) disable iff (rst_i) cmd_valid_o |=> !cmd_valid_o;
  endproperty
  a_cmd_pulse: assert property (p_cmd_pulse) else $error("cmd_valid_o too long");
  property p_cmd_hold;
    @(posedge clk_i) disable iff (rst_i) !cmd_valid_o |-> $stable(cmd_data_o);
  endproperty
  a_cmd_hold: assert property (p_cmd_hold) else $error("cmd_data_o moved");
  property p_disp_hold;
    @(posedge clk_i) disable iff (rst_i) !disp_valid_o |-> $stable({disp_mine_o, disp_data_o});
  endproperty
  a_disp_hold: assert property (p_disp_hold) else $error("display byte moved");
  property p_disp_mine;
    @(posedge clk_i) disable iff (rst_i) disp_valid_o |-> disp_mine_o == match;
  endproperty
  a_disp_mine: assert property (p_disp_mine) else $error("disp_mine_o wrong");
  property p_disp_end;
    @(posedge clk_i) disable iff (rst_i) disp_valid_o && ram_end_i |-> !disp_mine_o;
  endproperty
  a_disp_end: assert property (p_disp_end) else $error("byte kept past end");
  c_cmd: cover property (@(posedge clk_i) cmd_valid_o);
  c_mine: cover property (@(posedge clk_i) disp_valid_o && disp_mine_o);
  c_foreign: cover property (@(posedge clk_i) disp_valid_o && !disp_mine_o);
endmodule

bind lcdi_slave lcdi_slave_asserts u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .link_clk_i(link_clk_i), .scl_i(scl_i), .sda_o(sda_o),
  .sda_oe_n_o(sda_oe_n_o), .subaddr_strap_bit0_i(subaddr_strap_bit0_i),
  .subaddr_strap_bit1_i(subaddr_strap_bit1_i), .subaddr_strap_bit2_i(subaddr_strap_bit2_i),
  .subaddr_cur_i(subaddr_cur_i), .ram_end_i(ram_end_i), .cmd_valid_o(cmd_valid_o),
  .cmd_data_o(cmd_data_o), .disp_valid_o(disp_valid_o), .disp_mine_o(disp_mine_o),
  .disp_data_o(disp_data_o)
);

/* File: verification/testbench.sv */
// Self-checking bench of the serial write slave
`include "lcdi_defines.svh"
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i = 1'h0;
  logic link_clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic a_lsb = 1'h0;
  logic ram_end = 1'h0;
  logic [2:0] sub = 3'h0;
  logic [2:0] cur = 3'h0;
  logic scl, m_sda, sda_o, sda_oe_n, ack, cmd_v, disp_v, disp_m;
  logic [7:0] cmd_d, disp_d;
  logic [8:0] cmd_q[$];
  logic [8:0] disp_q[$];
  logic [7:0] adr[6] = '{8'h70, 8'h71, 8'h72, 8'h73, 8'h60, 8'h78};
  int num_errors = 0;
  int compares = 0;
  wire logic sda_w = m_sda & (sda_oe_n | sda_o);

  initial forever #25 clk_i = ~clk_i;
  initial
  begin
    #17;
    forever #62.5 link_clk_i = ~link_clk_i;
  end

  lcdi_slave u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .link_clk_i(link_clk_i), .scl_i(scl), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe_n_o(sda_oe_n), .addr_lsb_strap_i(a_lsb),
    .subaddr_strap_bit0_i(sub[0]), .subaddr_strap_bit1_i(sub[1]), .subaddr_strap_bit2_i(sub[2]),
    .subaddr_cur_i(cur), .ram_end_i(ram_end), .cmd_valid_o(cmd_v), .cmd_data_o(cmd_d),
    .disp_valid_o(disp_v), .disp_mine_o(disp_m), .disp_data_o(disp_d)
  );
  lcdi_bus_master u_mst (.sda_i(sda_w), .scl_o(scl), .sda_o(m_sda));

  // Outputs are launched on the rising edge, so collect them on the falling one
  always @(negedge clk_i)
  begin
    if (cmd_v === 1'h1)
      cmd_q.push_back({1'h0, cmd_d});
    if (disp_v === 1'h1)
      disp_q.push_back({disp_m, disp_d});
  end

  task automatic check(input string what, input logic [8:0] exp, input logic [8:0] got);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic setin(input logic a, input logic [2:0] s, input logic [2:0] c, input logic e);
    @(posedge clk_i);
    #1;
    a_lsb = a;
    sub = s;
    cur = c;
    ram_end = e;
  endtask
  // One whole byte with its expected ack
  task automatic wb(input logic [7:0] b, input logic exp);
    u_mst.send(b, 8, ack);
    check("ack", {8'h00, exp}, {8'h00, ack});
  endtask
  task automatic pop(input logic disp, input logic [8:0] exp);
    logic [8:0] got;
    got = 'x;
    if (disp && disp_q.size() > 0)
      got = disp_q.pop_front();
    if (!disp && cmd_q.size() > 0)
      got = cmd_q.pop_front();
    check(disp ? "disp" : "cmd", exp, got);
  endtask
  task automatic done(input string name);
    u_mst.stop();
    repeat (8) @(posedge clk_i);
    check("left", 9'h000, 9'(cmd_q.size() + disp_q.size()));
    $display("test %s done", name);
  endtask
  task automatic end_of_test();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    #4000000;
    num_errors++;
    end_of_test();
  end

  initial
  begin
    repeat (16) @(posedge clk_i);
    #1;
    rst_i = 1'h0;
    repeat (10) @(posedge clk_i);
    for (int s = 0; s < 2; s++)
    begin
      setin(s[0], 3'h0, 3'h0, 1'h0);
      foreach (adr[i])
      begin
        u_mst.start();
        wb(adr[i], adr[i][7:2] == `LCDI_ADDR_PREFIX && adr[i][1] == s[0] && !adr[i][0]);
        wb(8'h80, adr[i][7:2] == `LCDI_ADDR_PREFIX && adr[i][1] == s[0] && !adr[i][0]);
        u_mst.stop();
      end
    end
    done("address");
    setin(1'h0, 3'h0, 3'h0, 1'h0);
    u_mst.start();
    wb(8'h70, 1'h1);
    wb(8'h80, 1'h1);
    wb(8'ha5, 1'h1);
    wb(8'hc0, 1'h1);
    wb(8'h3c, 1'h1);
    wb(8'h00, 1'h1);
    wb(8'h41, 1'h1);
    wb(8'hc3, 1'h1);
    pop(1'h0, 9'h0a5);
    pop(1'h1, 9'h13c);
    pop(1'h0, 9'h041);
    pop(1'h0, 9'h0c3);
    done("route");
    setin(1'h1, 3'h5, 3'h4, 1'h0);
    u_mst.start();
    wb(8'h72, 1'h1);
    wb(8'h80, 1'h1);
    wb(8'h44, 1'h1);
    setin(1'h1, 3'h5, 3'h5, 1'h0);
    u_mst.start();
    wb(8'h72, 1'h1);
    wb(8'h40, 1'h1);
    wb(8'h11, 1'h1);
    setin(1'h1, 3'h5, 3'h4, 1'h0);
    wb(8'h22, 1'h0);
    setin(1'h1, 3'h5, 3'h5, 1'h1);
    wb(8'h33, 1'h0);
    pop(1'h0, 9'h044);
    pop(1'h1, 9'h111);
    pop(1'h1, 9'h022);
    pop(1'h1, 9'h033);
    done("subaddress");
    setin(1'h0, 3'h0, 3'h0, 1'h0);
    u_mst.start();
    wb(8'h70, 1'h1);
    wb(8'h80, 1'h1);
    u_mst.send(8'h99, 4, ack);
    u_mst.start();
    wb(8'h70, 1'h1);
    wb(8'h80, 1'h1);
    wb(8'h5a, 1'h1);
    pop(1'h0, 9'h05a);
    done("abort");
    end_of_test();
  end
endmodule
